// file: rtl/lwe_pkg.sv
// package: constants for the lock write and page/subsector erase link
package lwe_pkg;
  // ---------------------------------------------------------------
  // opcodes (arbitrary defaults)
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD_DEF = 8'h06;
  localparam logic [7:0] OPC_LOCK_DEF = 8'he5;
  localparam logic [7:0] OPC_PAGE_DEF = 8'hdb;
  localparam logic [7:0] OPC_SUB_DEF  = 8'h20;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int ADDR_MSB_USED = 18;
  localparam int PAGE_LSB      = 8;
  localparam int SUB_LSB       = 12;
  localparam int SECT_LSB      = 16;
  localparam int NUM_SECT      = 8;
  localparam int LOCK_WL_BIT   = 0;
  localparam int LOCK_LD_BIT   = 1;
  localparam logic [1:0] LOCK_RST = 2'h0;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ          = 125;
  localparam int PAGE_ERASE_US    = 10000;
  localparam int SUB_ERASE_US     = 50000;
  localparam int PAGE_ERASE_CYC   = PAGE_ERASE_US * CLK_MHZ;
  localparam int SUB_ERASE_CYC    = SUB_ERASE_US * CLK_MHZ;
  localparam int RESET_REC_NS     = 30000;
  localparam int RESET_REC_CYC    = (RESET_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int HOST_DIV_DEF     = 4;
  // ---------------------------------------------------------------
  // apb register map of the host controller
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STAT   = 8'h0c;
  localparam int CTRL_GO_BIT        = 8;
  localparam int CTRL_RST_BIT       = 9;
  localparam int STAT_BUSY_BIT      = 0;
  // command selection written to ctrl[1:0]
  typedef enum logic [1:0] {
    LWE_CMD_WRITE_ENABLE_CMD = 2'h0,
    LWE_CMD_LOCK = 2'h1,
    LWE_CMD_PAGE = 2'h2,
    LWE_CMD_SUB  = 2'h3
  } lwe_cmd_e;
endpackage

// file: rtl/lwe_link_if.sv
// interface: spi link between host controller and flash device
`timescale 1ns/1ps
interface lwe_link_if;
  logic cs_b;
  logic sclk;
  logic mosi;
  logic reset_b;
  modport host (output cs_b, output sclk, output mosi, output reset_b);
  modport dev  (input cs_b, input sclk, input mosi, input reset_b);
endinterface

// file: rtl/lwe_sync.sv
// two flop synchroniser for link pins
`timescale 1ns/1ps
module lwe_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // asynchronous pins
  input  wire logic [W-1:0] i_async,
  // synchronised
  output logic      [W-1:0] o_sync
);
  initial begin
    if (W < 1) $error("sync width must be at least one");
  end

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule

// file: rtl/lwe_dev.sv
// flash device end: instruction decode, lock bits, erase timing
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module lwe_dev #(
  parameter logic [7:0] OPC_WRITE_ENABLE_CMD = lwe_pkg::OPC_WRITE_ENABLE_CMD_DEF,
  parameter logic [7:0] OPC_LOCK = lwe_pkg::OPC_LOCK_DEF,
  parameter logic [7:0] OPC_PAGE = lwe_pkg::OPC_PAGE_DEF,
  parameter logic [7:0] OPC_SUB  = lwe_pkg::OPC_SUB_DEF,
  parameter int         PAGE_CYC = lwe_pkg::PAGE_ERASE_CYC,
  parameter int         SUB_CYC  = lwe_pkg::SUB_ERASE_CYC
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // link
  lwe_link_if.dev          link,
  // user side
  input  wire logic        i_hw_protect,
  output logic             o_wip,
  output logic             o_wel,
  output logic [7:0]       o_lock_bits,
  output logic             o_erase_pulse,
  output logic             o_erase_sub,
  output logic [18:0]      o_erase_addr,
  output logic             o_aborted
);
  initial begin
    if (PAGE_CYC < 1 || SUB_CYC < 1) $error("erase time must be at least one cycle");
  end

  // ---------------------------------------------------------------
  // pin sync and edge detect
  // ---------------------------------------------------------------
  logic [3:0] pins;
  logic       cs_s, sck_s, mosi_s, rstp_s;
  logic       sck_d_r, cs_d_r;
  // idle levels after reset: reset_b high, mosi low, sclk low, cs_b high
  lwe_sync #(.W(4), .RST_VAL(4'h9)) lwe_sync_i (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async ({link.reset_b, link.mosi, link.sclk, link.cs_b}),
    .o_sync  (pins)
  );
  assign cs_s   = pins[0];
  assign sck_s  = pins[1];
  assign mosi_s = pins[2];
  assign rstp_s = pins[3];
  wire sck_rise = sck_s && !sck_d_r;
  wire cs_rise  = cs_s && !cs_d_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r  <= cs_s;
    end
  end

  // ---------------------------------------------------------------
  // shift register and bit count
  // ---------------------------------------------------------------
  logic [5:0]  bits_r;
  logic [39:0] shift_r;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bits_r  <= 6'h00;
      shift_r <= 40'h0;
    end else if (cs_s || !rstp_s) begin
      bits_r <= 6'h00;
    end else if (sck_rise) begin
      shift_r <= {shift_r[38:0], mosi_s};
      if (bits_r != 6'h3f) bits_r <= bits_r + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // frame decode at cs rise
  // ---------------------------------------------------------------
  // exact bit count and opcode match
  function automatic logic frame_ok(input logic [5:0] cnt, input logic [5:0] want,
                                    input logic [7:0] opc, input logic [7:0] code);
    frame_ok = cnt == want && opc == code;
  endfunction

  wire [7:0] opc_write_enable_cmd = shift_r[7:0];
  wire [7:0] opc_a    = shift_r[31:24];
  wire [7:0] opc_l    = shift_r[39:32];
  wire [18:0] addr_a  = shift_r[18:0];
  wire [18:0] addr_l  = shift_r[26:8];
  wire [7:0] lock_d   = shift_r[7:0];
  wire is_write_enable_cmd = cs_rise && frame_ok(bits_r, 6'd8, opc_write_enable_cmd, OPC_WRITE_ENABLE_CMD);
  wire is_lock = cs_rise && frame_ok(bits_r, 6'd40, opc_l, OPC_LOCK);
  wire is_page = cs_rise && frame_ok(bits_r, 6'd32, opc_a, OPC_PAGE);
  wire is_sub  = cs_rise && frame_ok(bits_r, 6'd32, opc_a, OPC_SUB);

  // ---------------------------------------------------------------
  // lock bits, per sector
  // ---------------------------------------------------------------
  logic [1:0] lock_r [lwe_pkg::NUM_SECT];
  logic       wip_r;
  logic       wel_r;
  wire [2:0] sect_l = addr_l[18:16];
  wire [2:0] sect_a = addr_a[18:16];
  // lock write accepted: latch set, idle, sector not locked down
  wire lock_ok = is_lock && wel_r && !wip_r && !lock_r[sect_l][lwe_pkg::LOCK_LD_BIT];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < lwe_pkg::NUM_SECT; i++) lock_r[i] <= lwe_pkg::LOCK_RST;
    end else if (!rstp_s) begin
      for (int i = 0; i < lwe_pkg::NUM_SECT; i++) lock_r[i] <= lwe_pkg::LOCK_RST;
    end else if (lock_ok) begin
      lock_r[sect_l] <= lock_d[1:0];
    end
  end

  // ---------------------------------------------------------------
  // erase cycle
  // ---------------------------------------------------------------
  logic [31:0] cnt_r;
  logic        sub_r;
  logic [18:0] ea_r;
  logic        abort_r;
  wire prot_wl = lock_r[sect_a][lwe_pkg::LOCK_WL_BIT];
  wire ok_page = is_page && wel_r && !wip_r && !i_hw_protect && !prot_wl;
  wire ok_sub  = is_sub && wel_r && !wip_r && !i_hw_protect && !prot_wl;
  wire start   = ok_page || ok_sub;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wip_r   <= 1'b0;
      cnt_r   <= 32'h0;
      sub_r   <= 1'b0;
      ea_r    <= 19'h0;
      abort_r <= 1'b0;
    end else begin
      abort_r <= 1'b0;
      if (!rstp_s) begin
        abort_r <= wip_r;
        wip_r   <= 1'b0;
        cnt_r   <= 32'h0;
      end else if (start) begin
        wip_r <= 1'b1;
        sub_r <= ok_sub;
        cnt_r <= ok_sub ? 32'(SUB_CYC - 1) : 32'(PAGE_CYC - 1);
        ea_r  <= ok_sub ? {addr_a[18:12], 12'h000} : {addr_a[18:8], 8'h00};
      end else if (wip_r) begin
        if (cnt_r == 32'h0) wip_r <= 1'b0;
        else cnt_r <= cnt_r - 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // write enable latch
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wel_r <= 1'b0;
    end else if (!rstp_s) begin
      wel_r <= 1'b0;
    end else if (lock_ok) begin
      wel_r <= 1'b0;
    end else if (start) begin
      wel_r <= 1'b0;
    end else if (is_write_enable_cmd && !wip_r) begin
      wel_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // completion pulse with erase target (bytes become ff)
  // ---------------------------------------------------------------
  logic done_r;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) done_r <= 1'b0;
    else done_r <= wip_r && rstp_s && cnt_r == 32'h0 && !start;
  end

  assign o_wip         = wip_r;
  assign o_wel         = wel_r;
  assign o_lock_bits   = {6'h00, lock_r[sect_l]};
  assign o_erase_pulse = done_r;
  assign o_erase_sub   = sub_r;
  assign o_erase_addr  = ea_r;
  assign o_aborted     = abort_r;
endmodule

// file: rtl/lwe_host.sv
// host end: apb controlled spi frame generator
`timescale 1ns/1ps
module lwe_host #(
  parameter int DIV = lwe_pkg::HOST_DIV_DEF,
  parameter int REC = lwe_pkg::RESET_REC_CYC
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // apb
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // link
  lwe_link_if.host         link
);
  initial begin
    if (DIV < 2) $error("divider must be at least two");
  end

  logic [1:0]  cmd_r;
  logic [23:0] addr_r;
  logic [7:0]  data_r;
  logic        busy_r, rst_req_r;
  logic [39:0] sh_r;
  logic [5:0]  left_r;
  logic [15:0] div_r;
  logic [31:0] rec_r;
  logic        sck_r, cs_b_r, rstp_r;

  wire wr = i_psel && i_penable && i_pwrite;
  wire go = wr && i_paddr == lwe_pkg::REG_CTRL && i_pwdata[lwe_pkg::CTRL_GO_BIT] && !busy_r;

  // apb registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd_r     <= 2'h0;
      addr_r    <= 24'h0;
      data_r    <= 8'h00;
      rst_req_r <= 1'b0;
    end else begin
      rst_req_r <= 1'b0;
      if (wr && i_paddr == lwe_pkg::REG_CTRL) begin
        cmd_r     <= i_pwdata[1:0];
        rst_req_r <= i_pwdata[lwe_pkg::CTRL_RST_BIT];
      end
      if (wr && i_paddr == lwe_pkg::REG_ADDR) addr_r <= i_pwdata[23:0];
      if (wr && i_paddr == lwe_pkg::REG_DATA) data_r <= i_pwdata[7:0];
    end
  end

  always_comb begin
    case (i_paddr)
      lwe_pkg::REG_CTRL: o_prdata = {30'h0, cmd_r};
      lwe_pkg::REG_ADDR: o_prdata = {8'h00, addr_r};
      lwe_pkg::REG_DATA: o_prdata = {24'h0, data_r};
      lwe_pkg::REG_STAT: o_prdata = {31'h0, busy_r};
      default:           o_prdata = 32'h0;
    endcase
  end
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !(i_paddr == lwe_pkg::REG_CTRL ||
                     i_paddr == lwe_pkg::REG_ADDR || i_paddr == lwe_pkg::REG_DATA ||
                     i_paddr == lwe_pkg::REG_STAT);

  function automatic logic [7:0] opc_of(input logic [1:0] c);
    case (c)
      lwe_pkg::LWE_CMD_WRITE_ENABLE_CMD: opc_of = lwe_pkg::OPC_WRITE_ENABLE_CMD_DEF;
      lwe_pkg::LWE_CMD_LOCK: opc_of = lwe_pkg::OPC_LOCK_DEF;
      lwe_pkg::LWE_CMD_PAGE: opc_of = lwe_pkg::OPC_PAGE_DEF;
      default:               opc_of = lwe_pkg::OPC_SUB_DEF;
    endcase
  endfunction

  // frame engine: data changes on falling sck, device samples rising
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_r <= 1'b0;
      sh_r   <= 40'h0;
      left_r <= 6'h00;
      div_r  <= 16'h0;
      rec_r  <= 32'h0;
      sck_r  <= 1'b0;
      cs_b_r <= 1'b1;
      rstp_r <= 1'b1;
    end else if (rst_req_r && !busy_r) begin
      rstp_r <= 1'b0;
      rec_r  <= 32'(REC);
      busy_r <= 1'b1;
    end else if (!rstp_r || rec_r != 32'h0) begin
      rstp_r <= 1'b1;
      if (rec_r != 32'h0) rec_r <= rec_r - 32'h1;
      else busy_r <= 1'b0;
    end else if (go) begin
      busy_r <= 1'b1;
      cs_b_r <= 1'b0;
      div_r  <= 16'h0;
      case (i_pwdata[1:0])
        lwe_pkg::LWE_CMD_WRITE_ENABLE_CMD: begin
          sh_r   <= {opc_of(2'h0), 32'h0};
          left_r <= 6'd8;
        end
        lwe_pkg::LWE_CMD_LOCK: begin
          sh_r   <= {opc_of(2'h1), addr_r, 6'h00, data_r[1:0]};
          left_r <= 6'd40;
        end
        default: begin
          sh_r   <= {opc_of(i_pwdata[1:0]), addr_r, 8'h00};
          left_r <= 6'd32;
        end
      endcase
    end else if (busy_r) begin
      if (div_r == 16'(DIV - 1)) begin
        div_r <= 16'h0;
        if (left_r == 6'h00) begin
          cs_b_r <= 1'b1;
          busy_r <= 1'b0;
        end else if (!sck_r) begin
          sck_r <= 1'b1;
        end else begin
          sck_r  <= 1'b0;
          sh_r   <= {sh_r[38:0], 1'b0};
          left_r <= left_r - 6'h01;
        end
      end else begin
        div_r <= div_r + 16'h1;
      end
    end
  end

  assign link.cs_b    = cs_b_r;
  assign link.sclk    = sck_r;
  assign link.mosi    = sh_r[39];
  assign link.reset_b = rstp_r;
endmodule

// file: verif/lwe_link_assertions.sv
// checker: link framing and status timing
`timescale 1ns/1ps
module lwe_link_assertions #(
  parameter int CYC = 50
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // link and status
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic reset_b,
  input wire logic o_wip,
  input wire logic o_wel
);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic [15:0] wip_cnt_r;
  logic [3:0]  since_rst_r;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) wip_cnt_r <= 16'h0;
    else wip_cnt_r <= o_wip ? wip_cnt_r + 16'h1 : 16'h0;
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) since_rst_r <= 4'h0;
    else if (!reset_b) since_rst_r <= 4'h0;
    else if (since_rst_r != 4'hf) since_rst_r <= since_rst_r + 4'h1;
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence lead_low_s; !sclk[*3]; endsequence
  sequence high_phase_s; sclk[*4] ##1 !sclk; endsequence
  idle_clock_a: assert property (cs_b |-> !sclk)
    else $error("link clock active while deselected");
  frame_lead_a: assert property ($fell(cs_b) |-> lead_low_s)
    else $error("link clock rose too soon after select");
  high_phase_a: assert property ($rose(sclk) |-> high_phase_s)
    else $error("link clock high phase wrong");
  data_stable_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data changed while link clock high");
  reset_desel_a: assert property (!reset_b |-> cs_b)
    else $error("device selected during reset pulse");
  wel_set_a: assert property ($rose(o_wel) |-> cs_b && !o_wip)
    else $error("latch set outside a decoded frame");
  wip_hold_a: assert property ($rose(o_wip) |-> cs_b ##1 o_wip[*8])
    else $error("erase cycle not started cleanly");
  wip_end_a: assert property ($fell(o_wip) |-> !o_wel)
    else $error("latch still set after erase");
  wip_len_a: assert property ($fell(o_wip) && since_rst_r == 4'hf |->
    wip_cnt_r >= CYC - 2 && wip_cnt_r <= CYC + 2)
    else $error("erase duration wrong");
endmodule

// file: verif/test_lock_write_and_page_subsector_erase.sv
// testbench: host and device over the link, driven through apb
`timescale 1ns/1ps
module test_lock_write_and_page_subsector_erase;
  logic        i_clk;
  logic        i_rst_b;
  logic        psel, penable, pwrite, pready, pslverr, hw_protect, err;
  logic [7:0]  paddr, lock_bits;
  logic [31:0] pwdata, prdata, q;
  logic        write_in_progress, write_enable_latch, erase_pulse, erase_sub, aborted, last_sub;
  logic [18:0] erase_addr, last_addr;
  int          n_erase = 0, n_abort = 0, mismatches = 0, checks = 0;
  // erase longer than two frames so commands land inside a running cycle
  localparam int ERASE_CYC = 1000;
  lwe_link_if link ();
  lwe_host #(.REC(50)) lwe_host_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(link.host));
  lwe_dev #(.PAGE_CYC(ERASE_CYC), .SUB_CYC(ERASE_CYC)) lwe_dev_i (.i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .link(link.dev), .i_hw_protect(hw_protect), .o_wip(write_in_progress), .o_wel(write_enable_latch),
    .o_lock_bits(lock_bits), .o_erase_pulse(erase_pulse), .o_erase_sub(erase_sub),
    .o_erase_addr(erase_addr), .o_aborted(aborted));
  lwe_link_assertions #(.CYC(ERASE_CYC)) lwe_link_assertions_i (.i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .cs_b(link.cs_b), .sclk(link.sclk), .mosi(link.mosi), .reset_b(link.reset_b),
    .o_wip(write_in_progress), .o_wel(write_enable_latch));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (erase_pulse === 1'b1) begin
      n_erase++;
      last_addr = erase_addr;
      last_sub = erase_sub;
    end
    if (aborted === 1'b1) n_abort++;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task idle;
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, lwe_pkg::REG_STAT, 32'h0);
      if (q[0] === 1'b0) break;
    end
    chk({31'h0, q[0]}, 32'h0);
  endtask
  task cmd(input logic [1:0] c, input logic [23:0] a, input logic [7:0] d);
    idle();
    apb(1'b1, lwe_pkg::REG_ADDR, {8'h0, a});
    apb(1'b1, lwe_pkg::REG_DATA, {24'h0, d});
    apb(1'b1, lwe_pkg::REG_CTRL, {23'h0, 1'b1, 6'h0, c});
    idle();
    repeat (12) @(posedge i_clk);
  endtask
  task wait_wip;
    for (int i = 0; i < 2 * ERASE_CYC && write_in_progress !== 1'b0; i++) @(posedge i_clk);
    repeat (2) @(posedge i_clk);
    chk({31'h0, write_in_progress}, 32'h0);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge i_clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, hw_protect, i_rst_b} = '0;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    chk({write_in_progress, write_enable_latch, lock_bits}, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    $display("test reset done");
    cmd(lwe_pkg::LWE_CMD_PAGE, 24'h001000, 8'h0);
    chk(write_in_progress, 1'b0);
    cmd(lwe_pkg::LWE_CMD_WRITE_ENABLE_CMD, 24'h0, 8'h0);
    chk(write_enable_latch, 1'b1);
    cmd(lwe_pkg::LWE_CMD_PAGE, 24'hfd12a7, 8'h0);
    chk(write_in_progress, 1'b1);
    wait_wip();
    chk({last_sub, last_addr}, {1'b0, 19'h51200});
    chk({write_enable_latch, n_erase[3:0]}, 5'h1);
    $display("test page erase done");
    cmd(lwe_pkg::LWE_CMD_WRITE_ENABLE_CMD, 24'h0, 8'h0);
    cmd(lwe_pkg::LWE_CMD_SUB, 24'hfd12a7, 8'h0);
    chk(write_in_progress, 1'b1);
    cmd(lwe_pkg::LWE_CMD_LOCK, 24'h050000, 8'h03);
    chk({write_in_progress, lock_bits}, 9'h100);
    cmd(lwe_pkg::LWE_CMD_PAGE, 24'h000000, 8'h0);
    chk(write_in_progress, 1'b1);
    wait_wip();
    chk(n_erase, 2);
    chk({last_sub, last_addr}, {1'b1, 19'h51000});
    $display("test subsector and busy done");
    cmd(lwe_pkg::LWE_CMD_WRITE_ENABLE_CMD, 24'h0, 8'h0);
    cmd(lwe_pkg::LWE_CMD_LOCK, 24'h05ffff, 8'h01);
    chk({write_enable_latch, lock_bits}, 9'h001);
    cmd(lwe_pkg::LWE_CMD_WRITE_ENABLE_CMD, 24'h0, 8'h0);
    cmd(lwe_pkg::LWE_CMD_PAGE, 24'h050100, 8'h0);
    chk({write_in_progress, write_enable_latch}, 2'h1);
    cmd(lwe_pkg::LWE_CMD_LOCK, 24'h050000, 8'h02);
    cmd(lwe_pkg::LWE_CMD_WRITE_ENABLE_CMD, 24'h0, 8'h0);
    cmd(lwe_pkg::LWE_CMD_LOCK, 24'h050000, 8'h00);
    chk(lock_bits, 8'h02);
    $display("test lock done");
    hw_protect <= 1'b1;
    cmd(lwe_pkg::LWE_CMD_SUB, 24'h010000, 8'h0);
    chk(write_in_progress, 1'b0);
    cmd(lwe_pkg::LWE_CMD_PAGE, 24'h010000, 8'h0);
    chk(write_in_progress, 1'b0);
    hw_protect <= 1'b0;
    cmd(lwe_pkg::LWE_CMD_SUB, 24'h050000, 8'h0);
    chk(write_in_progress, 1'b1);
    apb(1'b1, lwe_pkg::REG_CTRL, 32'h200);
    repeat (12) @(posedge i_clk);
    chk({write_in_progress, write_enable_latch, n_abort[3:0]}, 6'h1);
    cmd(lwe_pkg::LWE_CMD_WRITE_ENABLE_CMD, 24'h0, 8'h0);
    cmd(lwe_pkg::LWE_CMD_LOCK, 24'h050000, 8'h01);
    chk(lock_bits, 8'h01);
    $display("test protect and abort done");
    give_verdict();
  end
endmodule
